// File: shared/ssf_pkg.sv
package ssf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BAUD  = 8'h0D;
  localparam logic [7:0] IDX_CTRL  = 8'h0F;
  localparam logic [7:0] IDX_FLAG  = 8'h10;
  localparam logic [7:0] IDX_DATA  = 8'h11;
  localparam logic [7:0] ADDR_BAUD = {IDX_BAUD[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_FLAG = {IDX_FLAG[5:0], 2'b00};
  localparam logic [7:0] ADDR_DATA = {IDX_DATA[5:0], 2'b00};

  // Flag register bit positions
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_TX_DONE  = 6;
  localparam int BIT_RX_FULL  = 5;
  localparam int BIT_QUIET    = 4;
  localparam int BIT_OVERRUN  = 3;
  localparam int BIT_NOISE    = 2;
  localparam int BIT_FRAMING  = 1;
  localparam logic [7:0] TX_FLAG_MASK = 8'hC0;
  localparam logic [7:0] RX_FLAG_MASK = 8'h3E;
  localparam logic [7:0] FLAG_RESET   = 8'hC0;

  // Control register: interrupt enables
  localparam int BIT_TX_EMPTY_IRQ_EN = 7;
  localparam int BIT_TX_DONE_IRQ_EN  = 6;
  localparam int BIT_RX_FULL_IRQ_EN  = 5;
  localparam int BIT_QUIET_IRQ_EN    = 4;
  localparam logic [7:0] CTRL_MASK   = 8'hF0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Baud register fields
  localparam int PRESCALE_LSB = 4;
  localparam int RATE_LSB     = 0;
  localparam logic [1:0] PRESCALE_RESET = 2'b00;
  localparam logic [3:0] PRESCALE_DIV0  = 4'h1;
  localparam logic [3:0] PRESCALE_DIV1  = 4'h3;
  localparam logic [3:0] PRESCALE_DIV2  = 4'h4;
  localparam logic [3:0] PRESCALE_DIV3  = 4'hD;

  // Consecutive idle bit times that mark a quiet line
  localparam logic [3:0] QUIET_BITS = 4'hA;

  typedef struct packed {
    logic [7:0] word;
    logic       noise;
    logic       stopBit;
  } ssf_rx_evt_t;

endpackage : ssf_pkg

// File: rtl/ssf_status_baud.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
module ssf_status_baud (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // APB slave
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Transmit datapath
  input  wire logic                txLoad,
  input  wire logic                txBusy,
  output logic      [7:0]          txData,
  output logic                     txWrite,
  // Receive datapath
  input  wire logic                rxValid,
  input  wire ssf_pkg::ssf_rx_evt_t rxEvt,
  input  wire logic                rxLine,
  // Shared rate and interrupt
  output logic                     baudTick,
  output logic                     irqReq
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ssf_pkg::ADDR_BAUD) || (a == ssf_pkg::ADDR_CTRL) ||
             (a == ssf_pkg::ADDR_FLAG) || (a == ssf_pkg::ADDR_DATA);
  endfunction : mapped

  function automatic logic [3:0] preDiv(input logic [1:0] sel);
    case (sel)
      2'b00:   preDiv = ssf_pkg::PRESCALE_DIV0;
      2'b01:   preDiv = ssf_pkg::PRESCALE_DIV1;
      2'b10:   preDiv = ssf_pkg::PRESCALE_DIV2;
      default: preDiv = ssf_pkg::PRESCALE_DIV3;
    endcase
  endfunction : preDiv

  function automatic logic [6:0] rateMask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    rateMask = m[6:0];
  endfunction : rateMask

  // State
  logic [7:0]  flags_ff;
  logic [7:0]  arm_ff;
  logic [7:0]  ctrl_ff;
  logic [1:0]  prescale_ff;
  logic [2:0]  rate_ff;
  logic [7:0]  rxBuf_ff;
  logic [31:0] prdata_ff;
  logic [7:0]  txData_ff;
  logic        txWrite_ff;
  logic        doneCond_ff;
  logic [3:0]  quietCnt_ff;
  logic [3:0]  preCnt_ff;
  logic [6:0]  rateCnt_ff;
  logic        baudTick_ff;
  logic        irqReq_ff;

  // Bus decode
  wire logic apbSetup  = psel & ~penable;
  wire logic apbAccess = psel & penable;
  wire logic wrEn      = apbAccess & pwrite;
  wire logic rdEn      = apbAccess & ~pwrite;
  wire logic dataWr    = wrEn & (paddr == ssf_pkg::ADDR_DATA);
  wire logic dataRd    = rdEn & (paddr == ssf_pkg::ADDR_DATA);
  wire logic flagRd    = rdEn & (paddr == ssf_pkg::ADDR_FLAG);
  wire logic ctrlWr    = wrEn & (paddr == ssf_pkg::ADDR_CTRL);
  wire logic baudWr    = wrEn & (paddr == ssf_pkg::ADDR_BAUD);

  wire logic [7:0] baudVal = {2'b00, prescale_ff, 1'b0, rate_ff};
  wire logic [7:0] readVal =
    (paddr == ssf_pkg::ADDR_BAUD) ? baudVal :
    (paddr == ssf_pkg::ADDR_CTRL) ? ctrl_ff :
    (paddr == ssf_pkg::ADDR_FLAG) ? flags_ff :
    (paddr == ssf_pkg::ADDR_DATA) ? rxBuf_ff : 8'h00;

  // Data access only clears flags whose arm was set by a prior flag read
  wire logic [7:0] accessMask = dataWr ? ssf_pkg::TX_FLAG_MASK :
                                dataRd ? ssf_pkg::RX_FLAG_MASK : 8'h00;
  wire logic [7:0] clrVec     = arm_ff & accessMask;
  // Flags seen are those latched into read data at setup, i.e. what software got
  wire logic [7:0] nxt_arm    = (arm_ff & ~accessMask) |
                                (flagRd ? prdata_ff[7:0] : 8'h00);

  // Transmit side; edge so a set flag cannot block its own clear
  wire logic doneCond = flags_ff[ssf_pkg::BIT_TX_EMPTY] & ~txBusy;
  wire logic doneSet  = doneCond & ~doneCond_ff;

  // Receive side
  wire logic rxHeld  = flags_ff[ssf_pkg::BIT_RX_FULL] &
                       ~clrVec[ssf_pkg::BIT_RX_FULL];
  wire logic rxLoad  = rxValid & ~rxHeld;
  wire logic rxOver  = rxValid & rxHeld;
  wire logic quietHit = baudTick_ff & rxLine &
                        (quietCnt_ff == ssf_pkg::QUIET_BITS - 4'h1);

  logic [7:0] setVec;
  always_comb begin
    setVec = 8'h00;
    setVec[ssf_pkg::BIT_TX_EMPTY] = txLoad;
    setVec[ssf_pkg::BIT_TX_DONE]  = doneSet;
    setVec[ssf_pkg::BIT_RX_FULL]  = rxLoad;
    setVec[ssf_pkg::BIT_QUIET]    = quietHit;
    setVec[ssf_pkg::BIT_OVERRUN]  = rxOver;
    setVec[ssf_pkg::BIT_NOISE]    = rxLoad & rxEvt.noise;
    // Framing only on a loaded word, so an overrun never sets it
    setVec[ssf_pkg::BIT_FRAMING]  = rxLoad & ~rxEvt.stopBit;
  end

  // Set wins over clear
  logic [7:0] nxt_flags;
  always_comb begin
    nxt_flags = (flags_ff & ~clrVec) | setVec;
    if (txBusy) begin
      nxt_flags[ssf_pkg::BIT_TX_DONE] = 1'b0;
    end
    nxt_flags[0] = 1'b0;
  end

  wire logic nxt_irq =
    (ctrl_ff[ssf_pkg::BIT_TX_EMPTY_IRQ_EN] & flags_ff[ssf_pkg::BIT_TX_EMPTY]) |
    (ctrl_ff[ssf_pkg::BIT_TX_DONE_IRQ_EN]  & flags_ff[ssf_pkg::BIT_TX_DONE])  |
    (ctrl_ff[ssf_pkg::BIT_RX_FULL_IRQ_EN]  & (flags_ff[ssf_pkg::BIT_RX_FULL] |
                                              flags_ff[ssf_pkg::BIT_OVERRUN])) |
    (ctrl_ff[ssf_pkg::BIT_QUIET_IRQ_EN]    & flags_ff[ssf_pkg::BIT_QUIET]);

  // Baud generator
  wire logic [3:0] preLast = preDiv(prescale_ff) - 4'h1;
  wire logic       preTick = (preCnt_ff >= preLast);
  wire logic [6:0] mask    = rateMask(rate_ff);
  wire logic       baudHit = preTick & ((rateCnt_ff & mask) == mask);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_ff    <= ssf_pkg::FLAG_RESET;
      arm_ff      <= 8'h00;
      doneCond_ff <= 1'b0;
      irqReq_ff   <= 1'b0;
    end else begin
      flags_ff    <= nxt_flags;
      arm_ff      <= nxt_arm;
      doneCond_ff <= doneCond;
      irqReq_ff   <= nxt_irq;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff     <= ssf_pkg::CTRL_RESET;
      prescale_ff <= ssf_pkg::PRESCALE_RESET;
    end else begin
      if (ctrlWr) begin
        ctrl_ff <= pwdata[7:0] & ssf_pkg::CTRL_MASK;
      end
      if (baudWr) begin
        prescale_ff <= pwdata[ssf_pkg::PRESCALE_LSB +: 2];
      end
    end
  end

  // Rate bits deliberately outside reset; power-up value is undefined
  always_ff @(posedge sys_clk) begin
    if (baudWr) begin
      rate_ff <= pwdata[ssf_pkg::RATE_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxBuf_ff <= 8'h00;
    end else if (rxLoad) begin
      rxBuf_ff <= rxEvt.word;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_ff  <= 32'h0000_0000;
      txData_ff  <= 8'h00;
      txWrite_ff <= 1'b0;
    end else begin
      if (apbSetup && !pwrite) begin
        prdata_ff <= {24'h00_0000, readVal};
      end
      if (dataWr) begin
        txData_ff <= pwdata[7:0];
      end
      txWrite_ff <= dataWr;
    end
  end

  // Counts idle bit times; saturates so one run of ones flags once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      quietCnt_ff <= 4'h0;
    end else if (!rxLine) begin
      quietCnt_ff <= 4'h0;
    end else if (baudTick_ff && quietCnt_ff != ssf_pkg::QUIET_BITS) begin
      quietCnt_ff <= quietCnt_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      preCnt_ff   <= 4'h0;
      rateCnt_ff  <= 7'h00;
      baudTick_ff <= 1'b0;
    end else begin
      preCnt_ff   <= preTick ? 4'h0 : preCnt_ff + 4'h1;
      rateCnt_ff  <= preTick ? rateCnt_ff + 7'h01 : rateCnt_ff;
      baudTick_ff <= baudHit;
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = 1'b1;
  assign pslverr  = apbAccess & ~mapped(paddr);
  assign txData   = txData_ff;
  assign txWrite  = txWrite_ff;
  assign baudTick = baudTick_ff;
  assign irqReq   = irqReq_ff;

endmodule : ssf_status_baud

// File: bench/ssf_status_baud_props.sv
`timescale 1ns/1ps
module ssf_status_baud_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  // Datapath
  input wire logic        txLoad,
  input wire logic        txBusy,
  input wire logic [7:0]  txData,
  input wire logic        txWrite,
  input wire logic        rxValid,
  input wire logic        baudTick,
  input wire logic        irqReq
);
  logic [7:0] ctl_ff;
  logic [7:0] bd_ff;
  logic [5:0] age_ff;
  wire        wrAcc = psel && penable && pwrite;
  wire        wrBaud = wrAcc && paddr == ssf_pkg::ADDR_BAUD;
  // Shadow copies; age hides the first 63 cycles after a rate change
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff <= 8'h00;
      bd_ff <= 8'h00;
      age_ff <= 6'h00;
    end else begin
      if (wrAcc && paddr == ssf_pkg::ADDR_CTRL) ctl_ff <= pwdata[7:0];
      if (wrBaud) bd_ff <= pwdata[7:0];
      age_ff <= wrBaud ? 6'h00 : age_ff + 6'((age_ff != 6'h3F));
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_tick_div_one: assert property (
    age_ff == 6'h3F && bd_ff == 8'h00 |-> baudTick) else $error("tick gap at divide one");
  chk_tick_div_thirteen: assert property (disable iff (!rstn || wrBaud)
    age_ff == 6'h3F && bd_ff == 8'h30 && baudTick |=> !baudTick [*8] ##5 baudTick)
    else $error("tick period not 13");
  chk_tick_rate_pow: assert property (disable iff (!rstn || wrBaud)
    age_ff == 6'h3F && bd_ff == 8'h12 && baudTick |=> !baudTick [*8] ##4 baudTick)
    else $error("tick period not 12");
  chk_irq_all_masked: assert property (
    (ctl_ff[7:4] == 4'h0) [*2] |-> !irqReq) else $error("irq with enables off");
  chk_rx_irq_raise: assert property (
    rxValid && ctl_ff[5] ##1 ctl_ff[5] |=> irqReq) else $error("no rx irq");
  chk_tx_irq_raise: assert property (
    txLoad && ctl_ff[7] ##1 ctl_ff[7] |=> irqReq) else $error("no tx empty irq");
  chk_done_while_busy: assert property (
    (txBusy && ctl_ff[7:4] == 4'h4) [*2] |=> !irqReq) else $error("done irq while busy");
  chk_data_write_out: assert property (
    wrAcc && paddr == ssf_pkg::ADDR_DATA |=> txWrite && txData == $past(pwdata[7:0]))
    else $error("data write not passed on");
  cover property (rxValid && ctl_ff[5]);
  cover property (txLoad && ctl_ff[7]);
  cover property (baudTick && bd_ff == 8'h30 && age_ff == 6'h3F);
endmodule : ssf_status_baud_props
bind ssf_status_baud ssf_status_baud_props chk_u (.sys_clk, .rstn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .txLoad, .txBusy, .txData, .txWrite, .rxValid, .baudTick, .irqReq);

// File: bench/ssf_far_model.sv
`timescale 1ns/1ps
module ssf_far_model (
  // Clock
  input wire logic             sys_clk,
  // Transmit side
  output logic                 txLoad,
  output logic                 txBusy,
  // Receive side
  output logic                 rxValid,
  output ssf_pkg::ssf_rx_evt_t rxEvt,
  output logic                 rxLine
);
  initial begin
    txLoad = 1'b0;
    txBusy = 1'b0;
    rxValid = 1'b0;
    rxEvt = '0;
    rxLine = 1'b1;
  end
  task automatic rx(input logic [7:0] w, input logic nz, input logic stp);
    @(posedge sys_clk);
    rxValid <= 1'b1;
    rxEvt <= '{word: w, noise: nz, stopBit: stp};
    @(posedge sys_clk);
    rxValid <= 1'b0;
    // Stale character must not look valid
    rxEvt <= ~rxEvt;
  endtask : rx
  task automatic tx(input logic go);
    @(posedge sys_clk);
    txLoad <= go;
    txBusy <= go;
    @(posedge sys_clk);
    txLoad <= 1'b0;
  endtask : tx
  task automatic line(input logic v);
    @(posedge sys_clk);
    rxLine <= v;
  endtask : line
endmodule : ssf_far_model

// File: bench/ssf_status_baud_bench.sv
`timescale 1ns/1ps
module ssf_status_baud_bench;
  logic                 sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr, txData, wd, w2;
  logic [31:0]          pwdata, prdata;
  logic                 txWrite, txLoad, txBusy, rxValid, rxLine, baudTick, irqReq;
  ssf_pkg::ssf_rx_evt_t rxEvt;
  logic [65:0]          expQ[$];
  logic [65:0]          e;
  int                   mismatches = 0;
  int                   total_checks = 0;
  ssf_status_baud dut_u (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .txLoad, .txBusy, .txData, .txWrite, .rxValid, .rxEvt, .rxLine,
    .baudTick, .irqReq);
  ssf_far_model far_u (.sys_clk, .txLoad, .txBusy, .rxValid, .rxEvt, .rxLine);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check_rd(input logic [32:0] exp, input logic [32:0] m, input logic [32:0] got);
    total_checks++;
    if (((got ^ exp) & m) !== 33'h0_0000_0000) begin
      mismatches++;
      $display("Error register read: expected %h seen %h", exp, got);
    end
  endtask : check_rd
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite) begin
      e = expQ.pop_front();
      check_rd(e[32:0], e[65:33], {pslverr, prdata});
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d,
                     input logic [32:0] m);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) expQ.push_back({m, d});
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {25'h000_0000, d}, 33'h0_0000_0000);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    apb(1'b0, a, {25'h000_0000, x}, {25'h1FF_FFFF, m});
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(21234));
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(ssf_pkg::ADDR_FLAG, 8'hC0, 8'hEF);
    rd(ssf_pkg::ADDR_BAUD, 8'h00, 8'h30);
    apb(1'b0, 8'h00, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    wr(ssf_pkg::ADDR_BAUD, 8'h00);
    repeat (80) @(posedge sys_clk);
    wr(ssf_pkg::ADDR_BAUD, 8'h30);
    repeat (100) @(posedge sys_clk);
    wr(ssf_pkg::ADDR_BAUD, 8'h12);
    repeat (100) @(posedge sys_clk);
    rd(ssf_pkg::ADDR_BAUD, 8'h12, 8'h37);
    wd = 8'($urandom);
    rd(ssf_pkg::ADDR_FLAG, 8'hC0, 8'hC0);
    wr(ssf_pkg::ADDR_DATA, wd);
    rd(ssf_pkg::ADDR_FLAG, 8'h00, 8'hC0);
    wr(ssf_pkg::ADDR_CTRL, 8'h80);
    far_u.tx(1'b1);
    rd(ssf_pkg::ADDR_FLAG, 8'h80, 8'hC0);
    wr(ssf_pkg::ADDR_CTRL, 8'h40);
    repeat (3) @(posedge sys_clk);
    far_u.tx(1'b0);
    repeat (2) @(posedge sys_clk);
    wr(ssf_pkg::ADDR_DATA, wd);
    rd(ssf_pkg::ADDR_FLAG, 8'h40, 8'hC0);
    wr(ssf_pkg::ADDR_DATA, ~wd);
    rd(ssf_pkg::ADDR_FLAG, 8'h00, 8'hC0);
    wr(ssf_pkg::ADDR_CTRL, 8'h20);
    w2 = 8'($urandom);
    far_u.rx(wd, 1'b0, 1'b1);
    far_u.rx(w2, 1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    rd(ssf_pkg::ADDR_FLAG, 8'h28, 8'h2E);
    rd(ssf_pkg::ADDR_DATA, wd, 8'hFF);
    rd(ssf_pkg::ADDR_FLAG, 8'h00, 8'h2E);
    far_u.rx(w2, 1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    rd(ssf_pkg::ADDR_FLAG, 8'h26, 8'h2E);
    rd(ssf_pkg::ADDR_DATA, w2, 8'hFF);
    rd(ssf_pkg::ADDR_FLAG, 8'h00, 8'h2E);
    far_u.line(1'b0);
    rd(ssf_pkg::ADDR_FLAG, 8'h00, 8'hFE);
    rd(ssf_pkg::ADDR_DATA, w2, 8'hFF);
    repeat (150) @(posedge sys_clk);
    rd(ssf_pkg::ADDR_FLAG, 8'h00, 8'h10);
    far_u.line(1'b1);
    repeat (90) @(posedge sys_clk);
    rd(ssf_pkg::ADDR_FLAG, 8'h00, 8'h10);
    repeat (60) @(posedge sys_clk);
    rd(ssf_pkg::ADDR_FLAG, 8'h10, 8'h10);
    // Mid-run reset: rate bits must survive it
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(ssf_pkg::ADDR_BAUD, 8'h02, 8'h37);
    rd(ssf_pkg::ADDR_FLAG, 8'hC0, 8'hEF);
    summarize();
  end
endmodule : ssf_status_baud_bench
